// File: dv/dmem_model.sv
// behavioural data memory answering the file port in the same cycle
`timescale 1ns/10ps

module dmem_model (
    input  wire logic                clk_i,
    input  pc_stack_pkg::dmem_req_s  req_i,
    output logic      [7:0]          rdata_o
);
    import pc_stack_pkg::*;

    logic [7:0] mem [512];
    logic [7:0] last_q;

    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 8'h00;
        end
        last_q = 8'h00;
    end

    // the pointed location holds the data, the port itself holds none
    always @(posedge clk_i) begin
        if (req_i.we) begin
            mem[req_i.addr] <= req_i.wdata;
        end
        if (req_i.re) begin
            last_q <= rdata_o;
        end
    end

    // not read: show the inverse of the last answer, never a stale match
    assign rdata_o = req_i.re ? mem[req_i.addr] : ~last_q;
endmodule

// File: dv/pc_stack_indirect_addressing_test.sv
// self-checking bench for the program counter, stack and indirect port
`timescale 1ns/10ps

module pc_stack_indirect_addressing_test;
    import pc_stack_pkg::*;

    logic       clk_i;
    logic       rst_n_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic       reg_we_i;
    logic       reg_re_i;
    logic [7:0] reg_rdata_o;
    seq_req_s   seq_req_i;
    logic       bank_i;
    pc_t        pc_o;
    dmem_req_s  dmem_req_o;
    logic [7:0] dmem_rdata_i;
    pc_t        pc_e;
    pc_t        st_e [8];
    logic [2:0] sp_e;
    logic [4:0] lat_e;
    int         error_cnt;
    int         compares;
    int         cyc;

    pc_stack_indirect_addressing pc_stack_indirect_addressing_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .seq_req_i(seq_req_i), .bank_select_high_bit_i(bank_i),
        .pc_o(pc_o), .dmem_req_o(dmem_req_o), .dmem_rdata_i(dmem_rdata_i)
    );

    dmem_model dmem_model_i (
        .clk_i(clk_i), .req_i(dmem_req_o), .rdata_o(dmem_rdata_i)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [12:0] s, input logic [12:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic final_report();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_we_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        if (a == 8'h0a) begin
            lat_e = d[4:0];
        end
        if (a == 8'h02) begin
            pc_e = {lat_e, d};
        end
        #1 chk(pc_o, pc_e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_re_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1 chk({5'h00, reg_rdata_o}, {5'h00, e});
    endtask

    // kind bits: irq, call, jump, return, step
    task automatic sq(input logic [4:0] k, input logic [10:0] t);
        @(posedge clk_i);
        seq_req_i <= {k, t};
        @(posedge clk_i);
        seq_req_i <= '0;
        if (k[4] || k[3]) begin
            st_e[sp_e] = pc_e;
            sp_e = sp_e + 3'h1;
        end
        if (k[4]) begin
            pc_e = 13'h0004;
        end else if (k[3] || k[2]) begin
            pc_e = {lat_e[4:3], t};
        end else if (k[1]) begin
            sp_e = sp_e - 3'h1;
            pc_e = st_e[sp_e];
        end else if (k[0]) begin
            pc_e = pc_e + 13'h0001;
        end
        #1 chk(pc_o, pc_e);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        {reg_addr_i, reg_wdata_i, reg_we_i, reg_re_i, bank_i} = '0;
        seq_req_i = '0;
        {pc_e, sp_e, lat_e, error_cnt, compares, cyc} = '0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1 chk(pc_o, 13'h0000);
        rd(8'h02, 8'h00);
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h1f);
        wr(8'h02, 8'ha5);
        rd(8'h02, 8'ha5);
        sq(5'b00001, 11'h000);
        wr(8'h0a, 8'h00);
        wr(8'h02, 8'hff);
        sq(5'b00001, 11'h000);
        wr(8'h0a, 8'h02);
        wr(8'h02, 8'h10);
        wr(8'h0a, 8'h18);
        sq(5'b00100, 11'h123);
        wr(8'h0a, 8'h07);
        sq(5'b00100, 11'h7ff);
        wr(8'h0a, 8'h08);
        sq(5'b10000, 11'h000);
        sq(5'b00010, 11'h000);
        for (int k = 0; k < 9; k++) begin
            sq(5'b01000, 11'(k * 37 + 1));
        end
        for (int k = 0; k < 9; k++) begin
            sq(5'b00010, 11'h000);
        end
        rd(8'h0a, 8'h08);
        wr(8'h04, 8'h30);
        wr(8'h00, 8'h5a);
        rd(8'h30, 8'h5a);
        bank_i <= 1'b1;
        rd(8'h00, 8'h5a);
        wr(8'h04, 8'h00);
        rd(8'h00, 8'h00);
        @(posedge clk_i);
        reg_we_i    <= 1'b1;
        reg_addr_i  <= 8'h00;
        reg_wdata_i <= 8'h77;
        #1 chk({12'h000, dmem_req_o.we}, 13'h0000);
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        rst_n_i  <= 1'b0;
        #1 chk(pc_o, 13'h0000);
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        {pc_e, sp_e, lat_e} = '0;
        rd(8'h0a, 8'h00);
        final_report();
    end
endmodule

// File: rtl/pc_stack_indirect_addressing.sv
// program counter, circular return stack and indirect data addressing
// Function
// RULE1 - program counter is 13 bits; its low byte is readable and writable
// RULE2 - upper counter bits are not software visible; loaded only from latch
// RULE3 - any reset clears the whole program counter to zero
// RULE4 - writing the low byte copies latch bits 4..0 into upper bits at once
// RULE5 - call and jump take only latch bits 4 and 3 into top counter bits
// RULE6 - call and jump fill counter bits 10..0 from the 11-bit target
// RULE7 - adding an offset into the low byte performs a computed jump
// RULE8 - return stack is eight entries of 13 bits outside all address spaces
// RULE9 - software can neither read nor write the stack pointer
// RULE10 - call or interrupt branch pushes the program counter
// RULE11 - return, return with literal, return from interrupt pop the stack
// RULE12 - the high latch is unchanged by every push and pop
// RULE13 - stack is circular; the ninth push overwrites the first entry
// RULE14 - no overflow or underflow status is provided
// RULE15 - indirect port has no storage; it reaches the pointed location
// RULE16 - reading the port while it points at itself returns 00h
// RULE17 - writing the port while it points at itself is discarded
// RULE18 - effective indirect address is bank bit above the 8-bit pointer
// RULE19 - bank bit has no effect here; only the pointer selects
// RULE20 - interrupt branch loads the fixed vector after pushing the return
`timescale 1ns/10ps
`include "pc_stack_params.svh"

module pc_stack_indirect_addressing #(
    parameter int STACK_DEPTH   = `STACK_DEPTH,
    parameter bit USE_BANK_BIT  = 1'b0
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // register file port
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   reg_we_i,
    input  wire logic                   reg_re_i,
    output logic      [7:0]             reg_rdata_o,
    // sequencing requests from the decoder
    input  pc_stack_pkg::seq_req_s      seq_req_i,
    input  wire logic                   bank_select_high_bit_i,
    output pc_stack_pkg::pc_t           pc_o,
    // data memory behind the file port
    output pc_stack_pkg::dmem_req_s     dmem_req_o,
    input  wire logic [7:0]             dmem_rdata_i
);
    import pc_stack_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    generate
        if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin
            $error("stack depth must be a power of two of at least two");
        end
    endgenerate

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pc_t                     pc_q;
    pc_t                     pc_d;
    logic [`LATCH_WIDTH-1:0] latch_q;
    logic [7:0]              pointer_q;
    logic [7:0]              rdata_q;
    logic [SP_W-1:0]         sp_q;
    pc_t                     stack_mem [STACK_DEPTH];

    logic       push;
    logic       pop;
    logic       pcl_wr;
    logic       ind_sel;
    logic       ind_self;
    logic       local_sel;
    data_addr_t eff_addr;
    pc_t        stack_top;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // interrupt outranks call; both push
    assign push   = seq_req_i.irq | seq_req_i.call; // RULE10
    assign pop    = ~push & ~seq_req_i.jump & seq_req_i.ret; // RULE11
    assign pcl_wr = reg_we_i & hit(reg_addr_i, `ADDR_PC_LOW_BYTE); // RULE7
    assign stack_top = stack_mem[sp_q - SP_W'(1)];

    assign ind_sel  = hit(reg_addr_i, `ADDR_INDIRECT_PORT);
    assign ind_self = hit(pointer_q, `ADDR_INDIRECT_PORT);
    assign eff_addr = {bank_select_high_bit_i & USE_BANK_BIT,
                       pointer_q}; // RULE18 RULE19

    // direct accesses to addresses kept inside this block never reach data memory
    assign local_sel = hit(reg_addr_i, `ADDR_PC_LOW_BYTE) |
                       hit(reg_addr_i, `ADDR_PC_HIGH_LATCH) |
                       hit(reg_addr_i, `ADDR_POINTER_REG);

    // ------------------------------------------------------------
    // next program counter
    // ------------------------------------------------------------
    always_comb begin
        pc_d = pc_q;
        if (seq_req_i.irq) begin
            pc_d = `IRQ_VECTOR; // RULE20
        end else if (seq_req_i.call || seq_req_i.jump) begin
            pc_d = {latch_q[`JUMP_PAGE_MSB:`JUMP_PAGE_LSB],
                    seq_req_i.target}; // RULE5 RULE6
        end else if (pop) begin
            pc_d = stack_top; // RULE11
        end else if (pcl_wr) begin
            pc_d = {latch_q, reg_wdata_i}; // RULE4 RULE2
        end else if (seq_req_i.step) begin
            pc_d = pc_q + pc_t'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_q <= `PC_RESET; // RULE3
        end else begin
            pc_q <= pc_d; // RULE1
        end
    end

    assign pc_o = pc_q;

    // ------------------------------------------------------------
    // high latch and pointer
    // ------------------------------------------------------------
    // only a software write moves the latch, never a push or pop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_q <= `LATCH_RESET;
        end else if (reg_we_i && hit(reg_addr_i, `ADDR_PC_HIGH_LATCH)) begin
            latch_q <= reg_wdata_i[`LATCH_WIDTH-1:0]; // RULE12
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pointer_q <= `POINTER_RESET;
        end else if (reg_we_i && hit(reg_addr_i, `ADDR_POINTER_REG)) begin
            pointer_q <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // return stack
    // ------------------------------------------------------------
    // pointer wraps freely and has no address; no overflow flag exists
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sp_q <= '0;
        end else if (push) begin
            sp_q <= sp_q + SP_W'(1); // RULE13 RULE9 RULE14
        end else if (pop) begin
            sp_q <= sp_q - SP_W'(1); // RULE13
        end
    end

    // storage sits outside both address spaces
    always_ff @(posedge clk_i) begin
        if (push) begin
            stack_mem[sp_q] <= pc_q; // RULE8 RULE10
        end
    end

    // ------------------------------------------------------------
    // data memory access and read back
    // ------------------------------------------------------------
    always_comb begin
        dmem_req_o.wdata = reg_wdata_i;
        if (ind_sel) begin
            dmem_req_o.addr = eff_addr; // RULE15
            dmem_req_o.we   = reg_we_i & ~ind_self; // RULE17
            dmem_req_o.re   = reg_re_i & ~ind_self;
        end else begin
            dmem_req_o.addr = {1'b0, reg_addr_i};
            dmem_req_o.we   = reg_we_i & ~local_sel;
            dmem_req_o.re   = reg_re_i & ~local_sel;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else if (reg_re_i) begin
            if (ind_sel && ind_self) begin
                rdata_q <= `INDIRECT_NULL_READ; // RULE16
            end else if (hit(reg_addr_i, `ADDR_PC_LOW_BYTE)) begin
                rdata_q <= pc_q[7:0]; // RULE1
            end else if (hit(reg_addr_i, `ADDR_PC_HIGH_LATCH)) begin
                rdata_q <= {3'h0, latch_q};
            end else if (hit(reg_addr_i, `ADDR_POINTER_REG)) begin
                rdata_q <= pointer_q;
            end else begin
                rdata_q <= dmem_rdata_i; // RULE15
            end
        end
    end

    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [`LATCH_WIDTH-1:0] latch_at_write_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_at_write_q <= '0;
        end else begin
            latch_at_write_q <= latch_q;
        end
    end

    pcl_write_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pcl_wr && !seq_req_i.irq && !seq_req_i.call && !seq_req_i.jump &&
        !seq_req_i.ret |=> pc_q == {latch_at_write_q, $past(reg_wdata_i)})
        else $error("low byte write did not load the full counter"); // RULE4

    jump_page_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !seq_req_i.irq && (seq_req_i.call || seq_req_i.jump) |=>
        pc_q[12:11] == latch_at_write_q[4:3] &&
        pc_q[10:0] == $past(seq_req_i.target))
        else $error("call or jump loaded wrong target"); // RULE5

    irq_vector_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        seq_req_i.irq |=> pc_q == `IRQ_VECTOR)
        else $error("interrupt did not vector"); // RULE20

    // a call, one cycle with no stack traffic, then a return
    call_return_pair_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        (seq_req_i.call && !seq_req_i.irq) ##1 (!push && !pop) ##1 pop
        |=> pc_q == $past(pc_q, 3))
        else $error("return did not restore pushed address"); // RULE11

    latch_push_pop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (push || pop) && !(reg_we_i &&
        hit(reg_addr_i, `ADDR_PC_HIGH_LATCH)) |=> $stable(latch_q))
        else $error("latch moved on push or pop"); // RULE12

    // modulo increment: the eighth push brings the pointer back to its start
    stack_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        push |=> sp_q == SP_W'($past(sp_q) + SP_W'(1)))
        else $error("stack pointer did not wrap after eight pushes"); // RULE13

    self_read_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_re_i && ind_sel && ind_self |=> reg_rdata_o == 8'h00)
        else $error("self indirect read not zero"); // RULE16

    self_write_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_we_i && ind_sel && ind_self |-> !dmem_req_o.we)
        else $error("self indirect write reached memory"); // RULE17

    indirect_addr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ind_sel && (reg_we_i || reg_re_i) && !ind_self |->
        dmem_req_o.addr == {1'b0, pointer_q} &&
        (dmem_req_o.we == reg_we_i))
        else $error("indirect access used wrong address"); // RULE15 RULE19

    pcl_read_back_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_re_i && hit(reg_addr_i, `ADDR_PC_LOW_BYTE) |=>
        reg_rdata_o == $past(pc_q[7:0]))
        else $error("low byte read back wrong"); // RULE1

    step_increment_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        seq_req_i.step && !push && !seq_req_i.jump && !seq_req_i.ret &&
        !pcl_wr |=> pc_q == pc_t'($past(pc_q) + pc_t'(1)))
        else $error("step did not advance the counter"); // RULE1

    push_store_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        push |=> stack_mem[$past(sp_q)] == $past(pc_q))
        else $error("push did not store the counter"); // RULE10

    pop_load_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        pop |=> pc_q == $past(stack_top))
        else $error("pop did not load the top entry"); // RULE11

    sp_pop_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        pop |=> sp_q == SP_W'($past(sp_q) - SP_W'(1)))
        else $error("pop did not step the pointer back"); // RULE13

    sp_hold_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !push && !pop |=> $stable(sp_q))
        else $error("stack pointer moved without push or pop"); // RULE9

    jump_no_push_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        seq_req_i.jump && !push |=> $stable(sp_q))
        else $error("jump touched the stack"); // RULE10

    // reset is asynchronous, so the counter reads zero at any edge in reset
    reset_pc_zero_a: assert property (@(posedge clk_i)
        !rst_n_i |-> pc_q == `PC_RESET)
        else $error("counter not cleared in reset"); // RULE3

    latch_only_sw_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !(reg_we_i && hit(reg_addr_i, `ADDR_PC_HIGH_LATCH))
        |=> $stable(latch_q))
        else $error("latch moved without a software write"); // RULE12

    latch_write_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        reg_we_i && hit(reg_addr_i, `ADDR_PC_HIGH_LATCH)
        |=> latch_q == $past(reg_wdata_i[`LATCH_WIDTH-1:0]))
        else $error("latch write lost"); // RULE2

    latch_read_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        reg_re_i && hit(reg_addr_i, `ADDR_PC_HIGH_LATCH)
        |=> reg_rdata_o == {3'h0, $past(latch_q)})
        else $error("latch read back wrong"); // RULE2

    pointer_write_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        reg_we_i && hit(reg_addr_i, `ADDR_POINTER_REG)
        |=> pointer_q == $past(reg_wdata_i))
        else $error("pointer write lost"); // RULE15

    pointer_read_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        reg_re_i && hit(reg_addr_i, `ADDR_POINTER_REG)
        |=> reg_rdata_o == $past(pointer_q))
        else $error("pointer read back wrong"); // RULE15

    mem_read_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        reg_re_i && !local_sel && !(ind_sel && ind_self)
        |=> reg_rdata_o == $past(dmem_rdata_i))
        else $error("data memory read not returned"); // RULE15

    self_read_quiet_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        reg_re_i && ind_sel && ind_self |-> !dmem_req_o.re)
        else $error("self indirect read reached memory"); // RULE16

    local_no_mem_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        local_sel && (reg_we_i || reg_re_i)
        |-> !dmem_req_o.we && !dmem_req_o.re)
        else $error("local register access reached memory"); // RULE2

    direct_addr_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !ind_sel && !local_sel && (reg_we_i || reg_re_i)
        |-> dmem_req_o.addr == {1'b0, reg_addr_i})
        else $error("direct access used wrong address"); // RULE18

    bank_ignored_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !USE_BANK_BIT |-> !dmem_req_o.addr[8])
        else $error("bank bit reached the data address"); // RULE19

    // read data stand until the next read strobe
    read_hold_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !reg_re_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read"); // RULE1

endmodule

// File: shared/pc_stack_params.svh
// constants for the program counter, return stack and indirect addressing
`ifndef PC_STACK_PARAMS_SVH
`define PC_STACK_PARAMS_SVH

// ------------------------------------------------------------
// register addresses on the file port
// ------------------------------------------------------------
`define ADDR_INDIRECT_PORT   8'h00
`define ADDR_PC_LOW_BYTE     8'h02
`define ADDR_POINTER_REG     8'h04
`define ADDR_PC_HIGH_LATCH   8'h0a

// ------------------------------------------------------------
// widths, fields and reset values
// ------------------------------------------------------------
`define PC_WIDTH             13
`define TARGET_WIDTH         11
`define LATCH_WIDTH          5
`define STACK_DEPTH          8
`define JUMP_PAGE_MSB        4
`define JUMP_PAGE_LSB        3
`define PC_RESET             13'h0000
`define LATCH_RESET          5'h00
`define POINTER_RESET        8'h00
`define IRQ_VECTOR           13'h0004
`define INDIRECT_NULL_READ   8'h00

`endif

// File: shared/pc_stack_pkg.sv
// types shared by the program sequencing and indirect addressing core
package pc_stack_pkg;

    typedef logic [12:0] pc_t;
    typedef logic [8:0]  data_addr_t;

    // one cycle of sequencing requests from the instruction decoder
    typedef struct packed {
        logic        irq;
        logic        call;
        logic        jump;
        logic        ret;
        logic        step;
        logic [10:0] target;
    } seq_req_s;

    // data memory access toward the file
    typedef struct packed {
        logic       we;
        logic       re;
        data_addr_t addr;
        logic [7:0] wdata;
    } dmem_req_s;

endpackage
